// File: rtl/ccr_pkg.sv
// constants and types of the common control register bank
package ccr_pkg;
	// register word indices as printed
	localparam logic [7:0] ADDR_RESET_CLEAR = 8'h19;
	localparam logic [7:0] ADDR_LOOP_DELAY = 8'h1A;
	localparam logic [7:0] ADDR_ALIGN_DEPTH = 8'h1B;
	localparam logic [7:0] ADDR_MEASURE_SEL = 8'h1C;
	localparam logic [7:0] ADDR_PIN_PAIRING = 8'h1D;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h21;
	// reset and clear control bits
	localparam int BIT_READY = 15;
	localparam int BIT_ERR_CLEAR = 3;
	localparam int BIT_FAIL_CLEAR = 2;
	localparam int BIT_COUNT_CLEAR = 1;
	localparam int BIT_SOFT_RESET = 0;
	// measure select fields
	localparam int BIT_STOP_EN = 11;
	localparam int BIT_STOP_SEL_LO = 8;
	localparam int BIT_START_EN = 7;
	localparam int BIT_START_SEL_LO = 4;
	localparam int BIT_ARM_EN = 3;
	localparam int BIT_ARM_SEL_LO = 0;
	localparam int SEL_W = 3;
	localparam int FIELD5_W = 5;
	localparam int PAIR_W = 2;
	localparam int IRQ_W = 2;
	localparam int IRQ_READY_RISE = 0;
	localparam int IRQ_READY_FALL = 1;
	// delay step and range
	localparam real LOOP_STEP_NS = 2.5;
	localparam real LOOP_MAX_NS = 80.0;
	localparam logic [4:0] RESET_FIELD5 = 5'h00;
	localparam logic [11:0] RESET_MEASURE = 12'h000;
	localparam logic [1:0] RESET_PAIR = 2'h0;
	localparam logic [15:0] ZERO16 = 16'h0000;
	typedef struct packed {
		logic [4:0] loop_delay_value;
		logic [4:0] align_depth;
		logic [11:0] measure_sel;
		logic [1:0] pairing;
		logic [1:0] irq_status;
		logic [1:0] irq_mask;
		logic ready_seen;
		logic [15:0] rdata;
	} ccr_state_type;
endpackage

// File: rtl/ccr_common_regs.sv
// common control register bank with measurement line selectors
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps

module ccr_common_regs (
	input wire logic clk_sys, // system clock
	input wire logic rst, // synchronous reset, high
	input wire logic [7:0] reg_addr, // register index
	input wire logic [15:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [15:0] reg_rdata, // read data, cycle after strobe
	input wire logic loop_locked, // lock flag from analog loops
	input wire logic [3:0] comp_high, // high comparator per channel
	input wire logic [3:0] comp_low, // low comparator per channel
	input wire logic [3:0] compare_fail_raw, // raw compare fails
	output logic [3:0] compare_fail_aligned, // fails delayed by align depth plus one cycle
	output logic err_clear_pulse, // clears delay errors, edge logic
	output logic fail_clear_pulse, // clears accumulated_fail_regs
	output logic count_clear_pulse, // clears fail counters
	output logic soft_reset_pulse, // software reset to whole chip
	output logic [4:0] loop_delay_value, // drive to compare delay code
	output logic [1:0] pair_enable, // channel pairing enables
	output logic arm_out, // arm line data
	output logic arm_oe_n, // arm line enable, low drives
	output logic start_out, // start line data
	output logic start_oe_n, // start line enable, low drives
	output logic stop_out, // stop line data
	output logic stop_oe_n, // stop line enable, low drives
	output logic irq // level interrupt
);

	// ============================================================
	// state
	ccr_pkg::ccr_state_type state_reg;
	ccr_pkg::ccr_state_type state_next;
	logic lock_meta_reg;
	logic lock_sync_reg;
	logic soft_reset_reg;
	logic [2:0] clears_reg;
	logic [3:0] fail_pipe_reg [0:31];
	logic [3:0] fail_out_reg;
	logic wr_ctrl;
	logic any_reset;
	logic [7:0] comp_vec;

	// software reset acts like the reset pin one cycle later, except on the lock flag synchroniser
	assign any_reset = rst | soft_reset_reg;

	// ============================================================
	// lock flag synchroniser
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lock_meta_reg <= 1'b0;
			lock_sync_reg <= 1'b0;
		end else begin
			lock_meta_reg <= loop_locked;
			lock_sync_reg <= lock_meta_reg;
		end
	end

	// ============================================================
	// clear and soft reset strobes
	assign wr_ctrl = reg_wr && (reg_addr == ccr_pkg::ADDR_RESET_CLEAR);

	// one-cycle pulses, zero writes leave them low
	always_ff @(posedge clk_sys) begin
		if (any_reset) begin
			soft_reset_reg <= 1'b0;
			clears_reg <= 3'h0;
		end else begin
			soft_reset_reg <= wr_ctrl && reg_wdata[ccr_pkg::BIT_SOFT_RESET];
			clears_reg[2] <= wr_ctrl && reg_wdata[ccr_pkg::BIT_ERR_CLEAR];
			clears_reg[1] <= wr_ctrl && reg_wdata[ccr_pkg::BIT_FAIL_CLEAR];
			clears_reg[0] <= wr_ctrl && reg_wdata[ccr_pkg::BIT_COUNT_CLEAR];
		end
	end

	assign err_clear_pulse = clears_reg[2];
	assign fail_clear_pulse = clears_reg[1];
	assign count_clear_pulse = clears_reg[0];
	assign soft_reset_pulse = soft_reset_reg;

	// ============================================================
	// register writes, reads and interrupt flags
	always_comb begin
		logic [1:0] ev;
		ev = 2'h0;
		state_next = state_reg;
		state_next.ready_seen = lock_sync_reg;
		ev[ccr_pkg::IRQ_READY_RISE] = lock_sync_reg & ~state_reg.ready_seen;
		ev[ccr_pkg::IRQ_READY_FALL] = ~lock_sync_reg & state_reg.ready_seen;
		state_next.rdata = ccr_pkg::ZERO16;
		if (reg_wr) begin
			if (reg_addr == ccr_pkg::ADDR_LOOP_DELAY) begin
				state_next.loop_delay_value = reg_wdata[ccr_pkg::FIELD5_W-1:0];
			end else if (reg_addr == ccr_pkg::ADDR_ALIGN_DEPTH) begin
				state_next.align_depth = reg_wdata[ccr_pkg::FIELD5_W-1:0];
			end else if (reg_addr == ccr_pkg::ADDR_MEASURE_SEL) begin
				state_next.measure_sel = reg_wdata[ccr_pkg::BIT_STOP_EN:0];
			end else if (reg_addr == ccr_pkg::ADDR_PIN_PAIRING) begin
				state_next.pairing = reg_wdata[ccr_pkg::PAIR_W-1:0];
			end else if (reg_addr == ccr_pkg::ADDR_IRQ_STATUS) begin
				state_next.irq_status = state_reg.irq_status & ~reg_wdata[ccr_pkg::IRQ_W-1:0];
			end else if (reg_addr == ccr_pkg::ADDR_IRQ_MASK) begin
				state_next.irq_mask = reg_wdata[ccr_pkg::IRQ_W-1:0];
			end
		end
		// set wins over write-one-to-clear
		state_next.irq_status = state_next.irq_status | ev;
		if (reg_rd) begin
			// unused bits read zero
			if (reg_addr == ccr_pkg::ADDR_RESET_CLEAR) begin
				state_next.rdata[ccr_pkg::BIT_READY] = lock_sync_reg;
			end else if (reg_addr == ccr_pkg::ADDR_LOOP_DELAY) begin
				state_next.rdata[ccr_pkg::FIELD5_W-1:0] = state_reg.loop_delay_value;
			end else if (reg_addr == ccr_pkg::ADDR_ALIGN_DEPTH) begin
				state_next.rdata[ccr_pkg::FIELD5_W-1:0] = state_reg.align_depth;
			end else if (reg_addr == ccr_pkg::ADDR_MEASURE_SEL) begin
				state_next.rdata[ccr_pkg::BIT_STOP_EN:0] = state_reg.measure_sel;
			end else if (reg_addr == ccr_pkg::ADDR_PIN_PAIRING) begin
				state_next.rdata[ccr_pkg::PAIR_W-1:0] = state_reg.pairing;
			end else if (reg_addr == ccr_pkg::ADDR_IRQ_STATUS) begin
				state_next.rdata[ccr_pkg::IRQ_W-1:0] = state_reg.irq_status;
			end else if (reg_addr == ccr_pkg::ADDR_IRQ_MASK) begin
				state_next.rdata[ccr_pkg::IRQ_W-1:0] = state_reg.irq_mask;
			end
		end
	end

	// state register, reset by pin or soft reset
	always_ff @(posedge clk_sys) begin
		if (any_reset) begin
			state_reg.loop_delay_value <= ccr_pkg::RESET_FIELD5;
			state_reg.align_depth <= ccr_pkg::RESET_FIELD5;
			state_reg.measure_sel <= ccr_pkg::RESET_MEASURE;
			state_reg.pairing <= ccr_pkg::RESET_PAIR;
			state_reg.irq_status <= 2'h0;
			state_reg.irq_mask <= 2'h0;
			state_reg.ready_seen <= 1'b0;
			state_reg.rdata <= ccr_pkg::ZERO16;
		end else begin
			state_reg <= state_next;
		end
	end

	assign reg_rdata = state_reg.rdata;
	assign loop_delay_value = state_reg.loop_delay_value;
	assign pair_enable = state_reg.pairing;
	assign irq = |(state_reg.irq_status & state_reg.irq_mask);

	// ============================================================
	// compare alignment pipeline, depth 0 passes straight through a flop
	always_ff @(posedge clk_sys) begin
		if (any_reset) begin
			for (int i = 0; i < 32; i++) begin
				fail_pipe_reg[i] <= 4'h0;
			end
			fail_out_reg <= 4'h0;
		end else begin
			fail_pipe_reg[0] <= compare_fail_raw;
			for (int i = 1; i < 32; i++) begin
				fail_pipe_reg[i] <= fail_pipe_reg[i-1];
			end
			fail_out_reg <= (state_reg.align_depth == ccr_pkg::RESET_FIELD5) ? compare_fail_raw
				: fail_pipe_reg[state_reg.align_depth - 5'h01];
		end
	end

	assign compare_fail_aligned = fail_out_reg;

	// ============================================================
	// measurement line selectors: code {channel, low}
	assign comp_vec = {comp_low[3], comp_high[3], comp_low[2], comp_high[2],
		comp_low[1], comp_high[1], comp_low[0], comp_high[0]};

	// selected comparator registered onto each line
	always_ff @(posedge clk_sys) begin
		if (any_reset) begin
			arm_out <= 1'b0;
			start_out <= 1'b0;
			stop_out <= 1'b0;
		end else begin
			arm_out <= comp_vec[state_reg.measure_sel[ccr_pkg::BIT_ARM_SEL_LO +: ccr_pkg::SEL_W]];
			start_out <= comp_vec[state_reg.measure_sel[ccr_pkg::BIT_START_SEL_LO +: ccr_pkg::SEL_W]];
			stop_out <= comp_vec[state_reg.measure_sel[ccr_pkg::BIT_STOP_SEL_LO +: ccr_pkg::SEL_W]];
		end
	end

	// enables, low while driving
	assign stop_oe_n = ~state_reg.measure_sel[ccr_pkg::BIT_STOP_EN];
	assign start_oe_n = ~state_reg.measure_sel[ccr_pkg::BIT_START_EN];
	assign arm_oe_n = ~state_reg.measure_sel[ccr_pkg::BIT_ARM_EN];

endmodule

// File: tb/ccr_common_regs_sva.sv
// assertions on the common control register bank ports
`timescale 1ns/1ps
module ccr_common_regs_sva (
	input wire logic clk_sys, // clock
	input wire logic rst, // reset
	input wire logic [7:0] reg_addr, // index
	input wire logic [15:0] reg_wdata, // data
	input wire logic reg_wr, // write
	input wire logic reg_rd, // read
	input wire logic [15:0] reg_rdata, // read data
	input wire logic err_clear_pulse, // pulse
	input wire logic fail_clear_pulse, // pulse
	input wire logic count_clear_pulse, // pulse
	input wire logic soft_reset_pulse, // pulse
	input wire logic [4:0] loop_delay_value, // delay code
	input wire logic arm_oe_n, // enable
	input wire logic start_oe_n, // enable
	input wire logic stop_oe_n // enable
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic ctl_wr;
	logic [2:0] clr;
	// clear writes without soft reset, and the pulses they make
	assign ctl_wr = reg_wr && reg_addr == ccr_pkg::ADDR_RESET_CLEAR && !reg_wdata[0];
	assign clr = {err_clear_pulse, fail_clear_pulse, count_clear_pulse};
	property p_err; ctl_wr && reg_wdata[3] |=> err_clear_pulse; endproperty
	a_err: assert property (p_err) else $error("error clear pulse missing");
	property p_fail; ctl_wr && reg_wdata[2] |=> fail_clear_pulse; endproperty
	a_fail: assert property (p_fail) else $error("fail clear pulse missing");
	property p_cnt; ctl_wr && reg_wdata[1] |=> count_clear_pulse; endproperty
	a_cnt: assert property (p_cnt) else $error("count clear pulse missing");
	property p_cause; clr != 3'h0 |-> $past(ctl_wr) && (clr & ~$past(reg_wdata[3:1])) == 3'h0; endproperty
	a_cause: assert property (p_cause) else $error("clear pulse without its write");
	property p_soft; reg_wr && reg_addr == ccr_pkg::ADDR_RESET_CLEAR && reg_wdata[0] |=>
		soft_reset_pulse ##1 (arm_oe_n && start_oe_n && stop_oe_n && loop_delay_value == 5'h00); endproperty
	a_soft: assert property (p_soft) else $error("soft reset did not reset");
	property p_rdd; reg_rd && reg_addr == ccr_pkg::ADDR_LOOP_DELAY |=> reg_rdata == {11'h000, $past(loop_delay_value)}; endproperty
	a_rdd: assert property (p_rdd) else $error("loop delay read wrong");
	property p_rdz; !reg_rd |=> reg_rdata == 16'h0000; endproperty
	a_rdz: assert property (p_rdz) else $error("read data outside read cycle");
	property p_oe; reg_wr && reg_addr == ccr_pkg::ADDR_MEASURE_SEL |=>
		{stop_oe_n, start_oe_n, arm_oe_n} == ~{$past(reg_wdata[11]), $past(reg_wdata[7]), $past(reg_wdata[3])}; endproperty
	a_oe: assert property (p_oe) else $error("line enable mismatch");
endmodule
bind ccr_common_regs ccr_common_regs_sva u_sva (.*);

// File: tb/ccr_tmu_model.sv
// measure lines as the time measure instrument sees them
`timescale 1ns/1ps
module ccr_tmu_model (
	input wire logic clk_sys, // clock
	input wire logic [2:0] line_out, // stop start arm data
	input wire logic [2:0] line_oe_n, // low drives
	output logic [2:0] line_seen // level at instrument
);
	logic flip = 1'b0;
	// floated lines show a changing pattern
	always @(posedge clk_sys) flip <= ~flip;
	assign line_seen = (line_out & ~line_oe_n) | ({3{flip}} & line_oe_n);
endmodule

// File: tb/tb_ccr_common_regs.sv
// self-checking bench of the common control register bank
`timescale 1ns/1ps
module tb_ccr_common_regs;
	logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, loop_locked = 1'b0, irq_a;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, lf = 16'h0034;
	logic [3:0] comp_high = 4'h0, comp_low = 4'h0, compare_fail_raw = 4'h0, compare_fail_aligned;
	logic err_clear_pulse, fail_clear_pulse, count_clear_pulse, soft_reset_pulse, irq;
	logic arm_out, arm_oe_n, start_out, start_oe_n, stop_out, stop_oe_n;
	logic [4:0] loop_delay_value, d;
	logic [1:0] pair_enable;
	logic [2:0] seen;
	int num_errors = 0, n_compared = 0, cyc = 0, n;
	ccr_common_regs dut (.*);
	ccr_tmu_model u_tmu (.clk_sys(clk_sys), .line_out({stop_out, start_out, arm_out}),
		.line_oe_n({stop_oe_n, start_oe_n, arm_oe_n}), .line_seen(seen));
	// clock and hang limit
	initial forever #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			num_errors++;
			conclude();
		end
	end
	function automatic logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic pick(input logic [2:0] c, input logic [3:0] h, input logic [3:0] l);
		return c[0] ? l[c[2:1]] : h[c[2:1]];
	endfunction
	task automatic chk(input logic [15:0] v, input logic [15:0] e);
		n_compared++;
		if (v !== e) begin
			num_errors++;
			$display("ERROR %0t: saw %h expected %h", $time, v, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] w);
		@(posedge clk_sys);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, w};
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk_sys);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask
	task conclude;
		$display("errors %0d compares %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		#1;
		chk({13'h0, arm_oe_n, start_oe_n, stop_oe_n}, 16'h0007);
		rd(ccr_pkg::ADDR_MEASURE_SEL, 16'h0000);
		rd(ccr_pkg::ADDR_RESET_CLEAR, 16'h0000);
		loop_locked <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rd(ccr_pkg::ADDR_RESET_CLEAR, 16'h8000);
		rd(8'h40, 16'h0000);
		rd(ccr_pkg::ADDR_IRQ_STATUS, 16'h0001);
		wr(ccr_pkg::ADDR_IRQ_MASK, 16'h0003);
		repeat (2) @(posedge clk_sys);
		irq_a = irq;
		wr(ccr_pkg::ADDR_IRQ_MASK, 16'h0000);
		repeat (2) @(posedge clk_sys);
		chk(irq_a != irq, 16'h0001);
		wr(ccr_pkg::ADDR_IRQ_STATUS, 16'h0001);
		rd(ccr_pkg::ADDR_IRQ_STATUS, 16'h0000);
		chk(irq, 16'h0000);
		// random registers, align depth kept legal
		for (int i = 0; i < 16; i++) begin
			lf = nxt(lf);
			d = 5'h13 + {1'b0, lf[15:12] % 4'hC};
			wr(ccr_pkg::ADDR_LOOP_DELAY, lf);
			wr(ccr_pkg::ADDR_ALIGN_DEPTH, {11'h000, d});
			wr(ccr_pkg::ADDR_PIN_PAIRING, lf);
			rd(ccr_pkg::ADDR_LOOP_DELAY, {11'h000, lf[4:0]});
			chk({11'h000, loop_delay_value}, {11'h000, lf[4:0]});
			rd(ccr_pkg::ADDR_ALIGN_DEPTH, {11'h000, d});
			rd(ccr_pkg::ADDR_PIN_PAIRING, {14'h0, lf[1:0]});
			chk({14'h0, pair_enable}, {14'h0, lf[1:0]});
		end
		// every selector code with random comparators
		for (int c = 0; c < 8; c++) begin
			lf = nxt(lf);
			{comp_high, comp_low} <= lf[7:0];
			wr(ccr_pkg::ADDR_MEASURE_SEL, {4'h0, 1'b1, 3'(c), 1'b1, 3'(c + 1), 1'b1, 3'(c + 2)});
			repeat (2) @(posedge clk_sys);
			#1;
			chk({13'h0, seen}, {13'h0, pick(3'(c), lf[7:4], lf[3:0]), pick(3'(c + 1), lf[7:4], lf[3:0]),
				pick(3'(c + 2), lf[7:4], lf[3:0])});
		end
		wr(ccr_pkg::ADDR_MEASURE_SEL, 16'h0777);
		chk({13'h0, stop_oe_n, start_oe_n, arm_oe_n}, 16'h0007);
		wr(ccr_pkg::ADDR_RESET_CLEAR, 16'h000E);
		chk({err_clear_pulse, fail_clear_pulse, count_clear_pulse}, 16'h0007);
		@(posedge clk_sys);
		#1;
		chk({err_clear_pulse, fail_clear_pulse, count_clear_pulse}, 16'h0000);
		wr(ccr_pkg::ADDR_RESET_CLEAR, 16'h0000);
		chk({err_clear_pulse, fail_clear_pulse, count_clear_pulse, soft_reset_pulse}, 16'h0000);
		// one fail word through the align pipeline
		@(posedge clk_sys);
		compare_fail_raw <= 4'hA;
		@(posedge clk_sys);
		compare_fail_raw <= 4'h0;
		n = 1;
		#1;
		while (compare_fail_aligned !== 4'hA && n < 40) begin
			@(posedge clk_sys);
			n++;
			#1;
		end
		chk(16'(n), 16'(d) + 16'h0001);
		wr(ccr_pkg::ADDR_RESET_CLEAR, 16'h0001);
		chk(soft_reset_pulse, 16'h0001);
		repeat (2) @(posedge clk_sys);
		rd(ccr_pkg::ADDR_LOOP_DELAY, 16'h0000);
		rd(ccr_pkg::ADDR_ALIGN_DEPTH, 16'h0000);
		conclude();
	end
endmodule
